// ### hdl/mcb_pkg.sv
// constants shared by both ends of the maintenance control byte link
package mcb_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  // byte addresses of the words reached by the host
  localparam logic [2:0] REG_MAINT = 3'h0;
  localparam logic [2:0] REG_INSTR_LO = 3'h4;
  localparam logic [2:0] REG_INSTR_HI = 3'h6;
  // bit positions inside the maintenance byte (high byte of word 0)
  localparam int BIT_STEP = 0;
  localparam int BIT_INJECT = 1;
  localparam int BIT_SHOW = 2;
  localparam int BIT_LOOP = 3;
  localparam int BIT_STEP_LINE = 4;
  localparam int BIT_RSVD = 5;
  localparam int BIT_MASTER_CLEAR_BIT = 6;
  localparam int BIT_RUN = 7;
  localparam logic [7:0] MAINT_RESET = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // timing at a 10 ns clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_PULSE_NS = 60;
  localparam int STEP_PULSES = 5;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_HZ = 1000 / CLK_PERIOD_NS * 1000000;
  localparam int RATE1_BPS = 10000;
  localparam int RATE2_BPS = 20000;
  localparam int MAINT_CYC_TYPE1 = CLK_HZ / RATE1_BPS;
  localparam int MAINT_CYC_TYPE2 = CLK_HZ / RATE2_BPS;
  localparam int TICK_W = 16;
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_STEP = 3'b010,
    OP_INJECT = 3'b011
  } mcb_op_t;
endpackage

// ### hdl/mcb_link_if.sv
// system bus word port between host program logic and the controller
`timescale 1ns/10ps
interface mcb_link_if;
  logic                           req;
  logic                           we;
  logic [mcb_pkg::ADDR_W-1:0]     addr;
  logic                           hi_en;
  logic                           lo_en;
  logic [mcb_pkg::DATA_W-1:0]     wdata;
  logic                           ack;
  logic [mcb_pkg::DATA_W-1:0]     rdata;
  modport dev (input req, input we, input addr, input hi_en, input lo_en,
               input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output hi_en, output lo_en,
                output wdata, input ack, input rdata);
endinterface

// ### hdl/mcb_ticker.sv
// free divider giving a one-cycle tick every DIV cycles while enabled
`timescale 1ns/10ps
module mcb_ticker #(
  parameter int unsigned DIV = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  localparam int            TW   = mcb_pkg::TICK_W;
  localparam logic [TW-1:0] LAST = TW'(DIV - 1);
  logic [TW-1:0]            cnt_reg;

  always_ff @(posedge clk)
  begin
    if (rst || !run || cnt_reg == LAST)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tick <= 1'b0;
    else
      tick <= run && cnt_reg == LAST;
  end
endmodule

// ### hdl/mcb_device.sv
// controller end: maintenance byte, step engine and line-unit test clocking
// How it works
// - step runs five 60 ns timing pulses
// - inject makes step use host instruction bytes
// - show-ROM turns bytes 4-7 into ROM
// - show-ROM with step shows next ROM word
// - line-loop ties serial out to in
// - loop without run: step-line is only clock
// - loop with run: internal maintenance bit clock
// - external loop needs test plug fitted
// - software sets full duplex before loopback
// - step-line rise shifts tx, fall rx
// - master clear inits processor and line unit, sets run
// - run gates clock, set by init
// - inhibit switch clears run, protect blocks microcode
// - lockout leaves only master clear working
// - maintenance actions override other controls; the inhibit switch still beats a run-bit write
// - maintenance byte is base word high byte
// - software loads word, steps, injects, unsteps
// - software halts run before stepping
// - single-step loop holds tx active, rts/dtr off
// - one step-line cycle shifts one bit
`timescale 1ns/10ps
module mcb_device #(
  parameter int unsigned MAINT_DIV_1 = mcb_pkg::MAINT_CYC_TYPE1,
  parameter int unsigned MAINT_DIV_2 = mcb_pkg::MAINT_CYC_TYPE2,
  parameter bit          LU_SECOND   = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  mcb_link_if.dev          bus,
  input  wire logic        bus_init,
  input  wire logic        maint_lockout_switch,
  input  wire logic        run_inhibit_switch,
  input  wire logic        run_protect_switch,
  input  wire logic        ucode_run_clear,
  input  wire logic [31:0] control_rom_word,
  input  wire logic [31:0] control_rom_next_word,
  input  wire logic        lu_serial_out,
  input  wire logic        ext_serial_rx,
  input  wire logic        modem_clk_pin,
  output logic             up_clk_en,
  output logic             up_clear,
  output logic             up_step_active,
  output logic             up_timing_pulse,
  output logic [2:0]       up_timing_index,
  output logic             up_use_injected,
  output logic [15:0]      up_injected_word,
  output logic             lu_clear,
  output logic             line_loop_bit,
  output logic             lu_serial_in,
  output logic             lu_tx_shift,
  output logic             lu_rx_shift,
  output logic             transmitter_active,
  output logic             lu_rts_hold_off,
  output logic             lu_dtr_hold_off
);
  localparam int NSYNC = 5;
  localparam logic [2:0] LAST_PULSE = 3'(mcb_pkg::STEP_PULSES - 1);
  localparam logic [2:0] LAST_SLOT_CYC = 3'(mcb_pkg::STEP_PULSE_CYC - 1);
  localparam logic       MAINT_RESET_RUN = mcb_pkg::MAINT_RESET[mcb_pkg::BIT_RUN];
  // pin inputs through two flops; only the second stage is ever read
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {modem_clk_pin, ext_serial_rx, run_protect_switch,
                    run_inhibit_switch, maint_lockout_switch};
  always_ff @(posedge clk)
  begin
    sync1_reg <= rst ? '0 : pin_raw;
    sync2_reg <= rst ? '0 : sync1_reg;
  end
  logic        lockout, inhibit, protect, ext_rx, modem_clk;
  assign {modem_clk, ext_rx, protect, inhibit, lockout} = sync2_reg;
  logic        step_reg, inject_reg, show_reg, loop_reg, step_line_reg, run_reg;
  logic [31:0] instr_reg;
  logic [7:0]  wbyte;
  logic        wr_maint, maint_ok, master_clear_bit_fire, step_start, step_active_reg;
  logic [2:0]  slot_cyc_reg, pulse_idx_reg;
  assign wbyte = bus.wdata[15:8];
  assign wr_maint = bus.req && bus.we && bus.hi_en && bus.addr == mcb_pkg::REG_MAINT;
  assign maint_ok = wr_maint && !lockout;
  assign master_clear_bit_fire = wr_maint && wbyte[mcb_pkg::BIT_MASTER_CLEAR_BIT];
  // only a 0->1 write of the step bit launches a cycle
  assign step_start = maint_ok && wbyte[mcb_pkg::BIT_STEP] && !step_reg
                      && !step_active_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      step_reg <= 1'b0;
      inject_reg <= 1'b0;
      show_reg <= 1'b0;
      loop_reg <= 1'b0;
      step_line_reg <= 1'b0;
    end
    else if (maint_ok)
    begin
      step_reg <= wbyte[mcb_pkg::BIT_STEP];
      inject_reg <= wbyte[mcb_pkg::BIT_INJECT];
      show_reg <= wbyte[mcb_pkg::BIT_SHOW];
      loop_reg <= wbyte[mcb_pkg::BIT_LOOP];
      step_line_reg <= wbyte[mcb_pkg::BIT_STEP_LINE];
    end
  end
  // init and master clear first, then inhibit, then maintenance write, microcode last
  always_ff @(posedge clk)
  begin
    if (rst)
      run_reg <= MAINT_RESET_RUN;
    else if (bus_init || master_clear_bit_fire)
      run_reg <= 1'b1;
    else if (inhibit)
      run_reg <= 1'b0;
    else if (maint_ok)
      run_reg <= wbyte[mcb_pkg::BIT_RUN];
    else if (ucode_run_clear && !protect)
      run_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      instr_reg <= '0;
    else if (bus.req && bus.we)
    begin
      if (bus.addr == mcb_pkg::REG_INSTR_LO && bus.lo_en)
        instr_reg[7:0] <= bus.wdata[7:0];
      if (bus.addr == mcb_pkg::REG_INSTR_LO && bus.hi_en)
        instr_reg[15:8] <= bus.wdata[15:8];
      if (bus.addr == mcb_pkg::REG_INSTR_HI && bus.lo_en)
        instr_reg[23:16] <= bus.wdata[7:0];
      if (bus.addr == mcb_pkg::REG_INSTR_HI && bus.hi_en)
        instr_reg[31:24] <= bus.wdata[15:8];
    end
  end
  // step engine: five back-to-back 60 ns slots; outputs move on the same edge so they agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      step_active_reg <= 1'b0;
      slot_cyc_reg <= '0;
      pulse_idx_reg <= '0;
      up_timing_pulse <= 1'b0;
      up_step_active <= 1'b0;
      up_timing_index <= '0;
    end
    else if (step_start)
    begin
      step_active_reg <= 1'b1;
      slot_cyc_reg <= '0;
      pulse_idx_reg <= '0;
      up_timing_pulse <= 1'b1;
      up_step_active <= 1'b1;
      up_timing_index <= '0;
    end
    else if (step_active_reg && slot_cyc_reg == LAST_SLOT_CYC)
    begin
      slot_cyc_reg <= '0;
      up_timing_pulse <= pulse_idx_reg != LAST_PULSE;
      step_active_reg <= pulse_idx_reg != LAST_PULSE;
      up_step_active <= pulse_idx_reg != LAST_PULSE;
      pulse_idx_reg <= pulse_idx_reg + 3'h1;
      up_timing_index <= pulse_idx_reg + 3'h1;
    end
    else
    begin
      up_timing_pulse <= 1'b0;
      if (step_active_reg)
        slot_cyc_reg <= slot_cyc_reg + 3'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      up_clk_en <= 1'b0;
      up_clear <= 1'b0;
      lu_clear <= 1'b0;
      up_use_injected <= 1'b0;
      up_injected_word <= '0;
    end
    else
    begin
      up_clk_en <= run_reg;
      up_clear <= master_clear_bit_fire;
      lu_clear <= master_clear_bit_fire;
      up_use_injected <= inject_reg;
      up_injected_word <= instr_reg[31:16];
    end
  end
  logic        maint_tick, step_line_d_reg, modem_d_reg;
  mcb_ticker #(.DIV (LU_SECOND ? MAINT_DIV_2 : MAINT_DIV_1)) u_maint_clk (
    .clk  (clk),
    .rst  (rst),
    .run  (run_reg),
    .tick (maint_tick)
  );
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      step_line_d_reg <= 1'b0;
      modem_d_reg <= 1'b0;
      lu_tx_shift <= 1'b0;
      lu_rx_shift <= 1'b0;
      line_loop_bit <= 1'b0;
      lu_serial_in <= 1'b0;
      transmitter_active <= 1'b0;
      lu_rts_hold_off <= 1'b0;
      lu_dtr_hold_off <= 1'b0;
    end
    else
    begin
      line_loop_bit <= loop_reg;
      lu_serial_in <= loop_reg ? lu_serial_out : ext_rx;
      transmitter_active <= loop_reg && !run_reg;
      lu_rts_hold_off <= loop_reg && !run_reg;
      lu_dtr_hold_off <= loop_reg && !run_reg;
      step_line_d_reg <= step_line_reg;
      modem_d_reg <= modem_clk;
      if (loop_reg && !run_reg)
      begin
        lu_tx_shift <= step_line_reg && !step_line_d_reg;
        lu_rx_shift <= !step_line_reg && step_line_d_reg;
      end
      else if (loop_reg)
      begin
        lu_tx_shift <= maint_tick;
        lu_rx_shift <= maint_tick;
      end
      else if (run_reg)
      begin
        // external plug mode: second type runs from its own modem clock
        lu_tx_shift <= LU_SECOND ? modem_clk && !modem_d_reg : maint_tick;
        lu_rx_shift <= LU_SECOND ? modem_clk && !modem_d_reg : maint_tick;
      end
      else
      begin
        lu_tx_shift <= 1'b0;
        lu_rx_shift <= 1'b0;
      end
    end
  end
  // register reads, answered one cycle after the request
  logic [7:0]  maint_rd;
  logic [31:0] rom_src;
  assign maint_rd = {run_reg, 1'b0, 1'b0, step_line_reg, loop_reg, show_reg,
                     inject_reg, step_reg};
  assign rom_src = step_reg ? control_rom_next_word : control_rom_word;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus.ack <= 1'b0;
      bus.rdata <= '0;
    end
    else
    begin
      bus.ack <= bus.req;
      if (bus.req && !bus.we)
        unique case (bus.addr)
          mcb_pkg::REG_MAINT:    bus.rdata <= {maint_rd, mcb_pkg::BYTE_ZERO};
          mcb_pkg::REG_INSTR_LO: bus.rdata <= show_reg ? rom_src[15:0] : instr_reg[15:0];
          mcb_pkg::REG_INSTR_HI: bus.rdata <= show_reg ? rom_src[31:16] : instr_reg[31:16];
          default:               bus.rdata <= '0;
        endcase
    end
  end
endmodule

// ### hdl/mcb_host.sv
// host end: turns user commands into maintenance bus sequences
`timescale 1ns/10ps
module mcb_host (
  input  wire logic                  clk,
  input  wire logic                  rst,
  mcb_link_if.host                   bus,
  input  wire logic                  cmd_valid,
  input  wire mcb_pkg::mcb_op_t      cmd_op,
  input  wire logic [2:0]            cmd_addr,
  input  wire logic                  cmd_hi,
  input  wire logic                  cmd_lo,
  input  wire logic [15:0]           cmd_wdata,
  input  wire logic                  full_duplex_ok,
  output logic                       cmd_ready,
  output logic                       cmd_refused,
  output logic                       rsp_valid,
  output logic [15:0]                rsp_rdata
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_WAIT = 2'b10
  } mcb_hstate_t;

  mcb_hstate_t      state_reg;
  mcb_pkg::mcb_op_t op_reg;
  logic [2:0]       addr_reg;
  logic             hi_reg;
  logic             lo_reg;
  logic [15:0]      data_reg;
  logic [1:0]       beat_reg;
  logic [7:0]       base;
  logic             loop_req;
  logic             last_beat;

  // step base keeps user bits but drops run, step and clear
  assign base = cmd_wdata[15:8] & ~(8'h1 << mcb_pkg::BIT_RUN) & ~(8'h1 << mcb_pkg::BIT_STEP)
                & ~(8'h1 << mcb_pkg::BIT_MASTER_CLEAR_BIT);
  assign loop_req = cmd_wdata[8 + mcb_pkg::BIT_LOOP]
                    && (cmd_op == mcb_pkg::OP_STEP || (cmd_op == mcb_pkg::OP_WRITE
                    && cmd_addr == mcb_pkg::REG_MAINT && cmd_hi));
  assign last_beat = op_reg == mcb_pkg::OP_READ || op_reg == mcb_pkg::OP_WRITE
                     || beat_reg == 2'h2;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= HS_IDLE;
      op_reg <= mcb_pkg::OP_READ;
      addr_reg <= '0;
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
      data_reg <= '0;
      beat_reg <= '0;
      cmd_refused <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      cmd_refused <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (state_reg)
        HS_IDLE:
          if (cmd_valid && loop_req && !full_duplex_ok)
            cmd_refused <= 1'b1;
          else if (cmd_valid)
          begin
            op_reg <= cmd_op;
            beat_reg <= '0;
            state_reg <= HS_SEND;
            unique case (cmd_op)
              mcb_pkg::OP_STEP:
              begin
                addr_reg <= mcb_pkg::REG_MAINT;
                {hi_reg, lo_reg} <= 2'b10;
                data_reg <= {base, mcb_pkg::BYTE_ZERO};
              end
              mcb_pkg::OP_INJECT:
              begin
                addr_reg <= mcb_pkg::REG_INSTR_HI;
                {hi_reg, lo_reg} <= 2'b11;
                data_reg <= cmd_wdata;
              end
              default:
              begin
                addr_reg <= cmd_addr;
                {hi_reg, lo_reg} <= {cmd_hi, cmd_lo};
                data_reg <= cmd_wdata;
              end
            endcase
          end
        HS_SEND:
          state_reg <= HS_WAIT;
        HS_WAIT:
          if (bus.ack && last_beat)
          begin
            rsp_valid <= 1'b1;
            rsp_rdata <= bus.rdata;
            state_reg <= HS_IDLE;
          end
          else if (bus.ack)
          begin
            beat_reg <= beat_reg + 2'h1;
            state_reg <= HS_SEND;
            addr_reg <= mcb_pkg::REG_MAINT;
            {hi_reg, lo_reg} <= 2'b10;
            if (op_reg == mcb_pkg::OP_INJECT)
              // set step with inject, then drop step keeping inject
              data_reg <= {(8'h1 << mcb_pkg::BIT_INJECT) | ((beat_reg == 2'h0)
                            ? (8'h1 << mcb_pkg::BIT_STEP) : 8'h0), mcb_pkg::BYTE_ZERO};
            else
              data_reg <= data_reg ^ {(8'h1 << mcb_pkg::BIT_STEP), mcb_pkg::BYTE_ZERO};
          end
        default:
          state_reg <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.addr <= '0;
      bus.hi_en <= 1'b0;
      bus.lo_en <= 1'b0;
      bus.wdata <= '0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      bus.req <= state_reg == HS_SEND;
      bus.we <= op_reg != mcb_pkg::OP_READ;
      bus.addr <= addr_reg;
      bus.hi_en <= hi_reg;
      bus.lo_en <= lo_reg;
      bus.wdata <= data_reg;
      cmd_ready <= state_reg == HS_IDLE && !cmd_valid;
    end
  end
endmodule

// ### tb/mcb_asserts.sv
// concurrent checks for the maintenance link and the controller end
`timescale 1ns/10ps
module mcb_asserts #(
  parameter int MAINT_DIV_1 = 8
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic        up_clk_en,
  input wire logic        up_clear,
  input wire logic        lu_clear,
  input wire logic        up_step_active,
  input wire logic        up_timing_pulse,
  input wire logic [2:0]  up_timing_index,
  input wire logic        line_loop_bit,
  input wire logic        lu_serial_in,
  input wire logic        lu_serial_out,
  input wire logic        lu_tx_shift,
  input wire logic        transmitter_active,
  input wire logic        lu_rts_hold_off
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ack_follows_req: assert property (req |=> ack)
    else $error("no acknowledge one cycle after request");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("acknowledge without request");
  a_step_five_pulses: assert property ($rose(up_step_active) |->
    up_timing_pulse && up_timing_index == 3'h0 ##6 up_timing_pulse ##6 up_timing_pulse
    ##6 up_timing_pulse ##6 up_timing_pulse && up_timing_index == 3'h4 ##6 !up_step_active)
    else $error("step cycle is not five timing pulses");
  a_step_from_write: assert property ($rose(up_step_active) |->
    $past(req) && $past(we) && $past(wdata[8]))
    else $error("step started without a step write");
  a_clear_both: assert property (up_clear == lu_clear)
    else $error("processor and line unit clears differ");
  a_clear_sets_run: assert property (up_clear |-> ##[0:2] up_clk_en)
    else $error("master clear did not enable the clock");
  a_loop_holds: assert property ((line_loop_bit && !up_clk_en)[*3] |->
    transmitter_active && lu_rts_hold_off)
    else $error("single step loop levels wrong");
  a_loop_serial: assert property (line_loop_bit && $past(line_loop_bit) && $past(line_loop_bit, 2) |->
    lu_serial_in == $past(lu_serial_out))
    else $error("serial output not looped to input");
  a_step_line_only: assert property ((line_loop_bit && !up_clk_en)[*4] ##0 lu_tx_shift |->
    $past(ack))
    else $error("line shift without a host write");
  a_loop_run_rate: assert property (lu_tx_shift && line_loop_bit && up_clk_en |->
    ##MAINT_DIV_1 (lu_tx_shift || !line_loop_bit || !up_clk_en))
    else $error("maintenance clock period wrong");
endmodule

// ### tb/test_maintenance_control_byte.sv
// self-checking bench joining both ends of the maintenance control byte link
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module test_maintenance_control_byte;
  localparam int DIV1 = 8;
  logic             clk = 1'h0, rst = 1'h1, bus_init = 1'h0, ucode_run_clear = 1'h0;
  logic             maint_lockout_switch = 1'h0, run_inhibit_switch = 1'h0;
  logic             run_protect_switch = 1'h0, full_duplex_ok = 1'h1;
  logic             lu_serial_out = 1'h0, ext_serial_rx = 1'h0, modem_clk_pin = 1'h0;
  logic [31:0]      control_rom_word = 32'h0, control_rom_next_word = 32'h0;
  logic             cmd_valid = 1'h0, cmd_hi = 1'h0, cmd_lo = 1'h0;
  mcb_pkg::mcb_op_t cmd_op = mcb_pkg::OP_READ;
  logic [2:0]       cmd_addr = 3'h0, up_timing_index;
  logic [15:0]      cmd_wdata = 16'h0, up_injected_word, rsp_rdata, w;
  logic             up_clk_en, up_clear, up_step_active, up_timing_pulse, up_use_injected;
  logic             lu_clear, line_loop_bit, lu_serial_in, lu_tx_shift, lu_rx_shift;
  logic             transmitter_active, lu_rts_hold_off, lu_dtr_hold_off;
  logic             cmd_ready, cmd_refused, rsp_valid;
  logic [32:0]      exp_q[$];
  logic [32:0]      e;
  logic [7:0]       v;
  int               mismatches = 0, checks_done = 0, pc = 0, txc = 0, rxc = 0, clrc = 0;
  int               t0, p0, c0, i;

  mcb_link_if i_mcb_link_if ();
  mcb_device #(.MAINT_DIV_1(DIV1), .MAINT_DIV_2(DIV1 / 2), .LU_SECOND(1'h0)) i_mcb_device (
    .clk, .rst, .bus(i_mcb_link_if), .bus_init, .maint_lockout_switch, .run_inhibit_switch,
    .run_protect_switch, .ucode_run_clear, .control_rom_word, .control_rom_next_word, .lu_serial_out,
    .ext_serial_rx, .modem_clk_pin, .up_clk_en, .up_clear, .up_step_active, .up_timing_pulse,
    .up_timing_index, .up_use_injected, .up_injected_word, .lu_clear, .line_loop_bit, .lu_serial_in,
    .lu_tx_shift, .lu_rx_shift, .transmitter_active, .lu_rts_hold_off, .lu_dtr_hold_off);
  mcb_host i_mcb_host (
    .clk, .rst, .bus(i_mcb_link_if), .cmd_valid, .cmd_op, .cmd_addr, .cmd_hi, .cmd_lo,
    .cmd_wdata, .full_duplex_ok, .cmd_ready, .cmd_refused, .rsp_valid, .rsp_rdata);
  mcb_asserts #(.MAINT_DIV_1(DIV1)) i_mcb_asserts (
    .clk, .rst, .req(i_mcb_link_if.req), .we(i_mcb_link_if.we), .wdata(i_mcb_link_if.wdata),
    .ack(i_mcb_link_if.ack), .up_clk_en, .up_clear, .lu_clear, .up_step_active,
    .up_timing_pulse, .up_timing_index, .line_loop_bit, .lu_serial_in, .lu_serial_out,
    .lu_tx_shift, .transmitter_active, .lu_rts_hold_off);

  always #5 clk = ~clk;

  // random serial traffic so a stuck loop path cannot match by luck
  always @(posedge clk)
  begin
    lu_serial_out <= 1'($urandom);
    ext_serial_rx <= 1'($urandom);
    modem_clk_pin <= ~modem_clk_pin;
  end

  // results come back in order; looked at mid-cycle, clear of the launching edge
  always @(negedge clk)
  begin
    if (rsp_valid === 1'h1 || cmd_refused === 1'h1)
    begin
      `CHK(exp_q.size() != 0, 1'h1);
      if (exp_q.size() != 0)
      begin
        e = exp_q.pop_front();
        `CHK(cmd_refused, e[32]);
        `CHK(rsp_rdata & e[31:16], e[15:0]);
      end
    end
    if (up_timing_pulse === 1'h1) pc++;
    if (lu_tx_shift === 1'h1) txc++;
    if (lu_rx_shift === 1'h1) rxc++;
    if (up_clear === 1'h1) clrc++;
  end

  task automatic stop_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'h1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic cmd(input mcb_pkg::mcb_op_t op, input logic [2:0] a, input logic [1:0] ln,
                     input logic [15:0] wd, input logic [32:0] ex);
    wait_ready();
    exp_q.push_back(ex);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= a;
    {cmd_hi, cmd_lo} <= ln;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'h0;
  endtask

  task automatic wm(input logic [7:0] b);
    cmd(mcb_pkg::OP_WRITE, 3'h0, 2'h2, {b, 8'h00}, 33'h0);
  endtask

  task automatic rm(input logic [7:0] b);
    cmd(mcb_pkg::OP_READ, 3'h0, 2'h2, 16'h0, {1'h0, 16'hff00, b, 8'h00});
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] d);
    cmd(mcb_pkg::OP_READ, a, 2'h3, 16'h0, {1'h0, 16'hffff, d});
  endtask

  task automatic pause(input int n);
    wait_ready();
    repeat (n) @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    void'($urandom(67180));
    control_rom_word = $urandom;
    control_rom_next_word = $urandom;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rm(8'h80);
    for (i = 0; i < 4; i++)
    begin
      v = 8'($urandom) & 8'hb6;
      wm(v);
      rm(v & 8'h9f);
    end
    cmd(mcb_pkg::OP_WRITE, 3'h2, 2'h3, 16'hffff, 33'h0);
    rd(3'h2, 16'h0);
    pause(1);
    full_duplex_ok <= 1'h0;
    cmd(mcb_pkg::OP_WRITE, 3'h0, 2'h2, 16'h0800, {1'h1, 32'h0});
    pause(1);
    full_duplex_ok <= 1'h1;
    wm(8'h00);
    p0 = pc;
    cmd(mcb_pkg::OP_STEP, 3'h0, 2'h2, 16'h0, 33'h0);
    pause(40);
    `CHK(pc - p0, 5);
    // the second write finds the step bit already set
    wm(8'h01);
    wm(8'h01);
    pause(40);
    `CHK(pc - p0, 10);
    wm(8'h00);
    w = 16'($urandom);
    cmd(mcb_pkg::OP_INJECT, 3'h0, 2'h3, w, 33'h0);
    pause(40);
    `CHK(pc - p0, 15);
    `CHK(up_use_injected, 1'h1);
    `CHK(up_injected_word, w);
    rd(3'h6, w);
    wm(8'h04);
    rd(3'h4, control_rom_word[15:0]);
    rd(3'h6, control_rom_word[31:16]);
    wm(8'h05);
    rd(3'h4, control_rom_next_word[15:0]);
    wm(8'h04);
    pause(4);
    maint_lockout_switch <= 1'h1;
    pause(4);
    wm(8'h10);
    rm(8'h04);
    c0 = clrc;
    wm(8'h40);
    rm(8'h84);
    `CHK(clrc - c0, 1);
    maint_lockout_switch <= 1'h0;
    wm(8'h08);
    pause(3);
    `CHK({transmitter_active, lu_rts_hold_off, lu_dtr_hold_off}, 3'h7);
    t0 = txc;
    c0 = rxc;
    for (i = 0; i < 3; i++)
    begin
      wm(8'h18);
      wm(8'h08);
    end
    pause(4);
    `CHK(txc - t0, 3);
    `CHK(rxc - c0, 3);
    for (i = 0; i < 2; i++)
    begin
      wm(i == 0 ? 8'h88 : 8'h80);
      pause(2);
      t0 = txc;
      repeat (10 * DIV1) @(posedge clk);
      `CHK((txc - t0) inside {[9:11]}, 1'h1);
    end
    wm(8'h00);
    pause(1);
    bus_init <= 1'h1;
    @(posedge clk) bus_init <= 1'h0;
    rm(8'h80);
    for (i = 1; i >= 0; i--)
    begin
      pause(1);
      run_protect_switch <= i[0];
      repeat (4) @(posedge clk);
      ucode_run_clear <= 1'h1;
      @(posedge clk) ucode_run_clear <= 1'h0;
      rm(i[0] ? 8'h80 : 8'h00);
    end
    wm(8'h80);
    pause(1);
    run_inhibit_switch <= 1'h1;
    pause(4);
    rm(8'h00);
    pause(10);
    stop_test();
  end
endmodule
